//--- rtl/ata_cmd_pkg.sv
// Constants and types for the capacity-limit and block-count command block
package ata_cmd_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_DRIVE_HEAD = 8'h04;
  localparam logic [7:0] OFF_LBA_HIGH = 8'h08;
  localparam logic [7:0] OFF_LBA_MID = 8'h0C;
  localparam logic [7:0] OFF_LBA_LOW = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  localparam logic [7:0] OFF_SUBCMD = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MAX_LBA = 8'h20;
  localparam logic [7:0] OFF_NV_LBA = 8'h24;
  localparam logic [7:0] OFF_BLOCK = 8'h28;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  // Register indices returned by the decoder
  localparam logic [3:0] IDX_COMMAND = 4'h0;
  localparam logic [3:0] IDX_DRIVE_HEAD = 4'h1;
  localparam logic [3:0] IDX_LBA_HIGH = 4'h2;
  localparam logic [3:0] IDX_LBA_MID = 4'h3;
  localparam logic [3:0] IDX_LBA_LOW = 4'h4;
  localparam logic [3:0] IDX_COUNT = 4'h5;
  localparam logic [3:0] IDX_SUBCMD = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h7;
  localparam logic [3:0] IDX_MAX_LBA = 4'h8;
  localparam logic [3:0] IDX_NV_LBA = 4'h9;
  localparam logic [3:0] IDX_BLOCK = 4'hA;
  localparam logic [3:0] IDX_IRQ_STAT = 4'hB;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hC;
  localparam logic [3:0] IDX_NONE = 4'hF;
  // Command codes
  localparam logic [7:0] CMD_SET_MAX = 8'hF9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
  localparam logic [7:0] CMD_SET_MULTI = 8'hC6;
  localparam logic [7:0] CMD_READ_SECTORS = 8'h20;
  localparam logic [7:0] CMD_WRITE_SECTORS = 8'h30;
  localparam logic [7:0] CMD_READ_MULTI = 8'hC4;
  localparam logic [7:0] CMD_WRITE_MULTI = 8'hC5;
  // Field positions
  localparam int DH_LBA_MODE_BIT = 6;
  localparam int DH_SELECT_BIT = 4;
  localparam int COUNT_PERSIST_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERROR_BIT = 1;
  localparam int ST_ABORT_BIT = 2;
  localparam int ST_MULTI_BIT = 3;
  localparam int ST_RANGE_BIT = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  // Reset values and bus answers
  localparam logic [7:0] TF_RESET = 8'h00;
  localparam logic [27:0] LBA_RESET = 28'h0000000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_IDLE,
    ST_EXEC
  } cmd_state_type;
endpackage : ata_cmd_pkg

//--- rtl/capacity_limit_and_block_count_cmds.sv
// Task-file command block: maximum address, native capacity and block count
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Command F9h replaces the current highest accessible block address.
// - Block address needs mode bit set; limit built from head, high, mid, low.
// - Only the device whose select bit matches acts on a command.
// - Count bit 0 set keeps limit over reset; clear reverts to non-volatile.
// - A second non-volatile limit change since reset is aborted.
// - Command F8h reports the true native highest address.
// - Command C6h takes sectors per block from the count register.
// - Block-count command raises busy, then checks the count.
// - A supported count is stored and multi-sector commands enabled.
// - An unsupported count aborts and disables multi-sector commands.
// - A zero count disables multi-sector commands without error.
// - Multi-sector commands start disabled after reset.
module capacity_limit_and_block_count_cmds #(
  parameter logic [27:0] NATIVE_MAX_LBA = 28'h3FFFFFF,
  parameter logic [7:0] MAX_BLOCK = 8'h10,
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic device_position,
  input wire logic [27:0] nv_limit_in,
  output logic [27:0] nv_limit_out,
  output logic nv_limit_write,
  output logic [27:0] max_lba,
  output logic [7:0] block_count,
  output logic multi_enable,
  output logic device_busy_flag,
  output logic irq
);
  typedef struct packed {
    ata_cmd_pkg::cmd_state_type state;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] command_code;
    logic [7:0] drive_head_select;
    logic [7:0] lba_high_byte;
    logic [7:0] lba_mid_byte;
    logic [7:0] lba_low_byte;
    logic [7:0] transfer_count_param;
    logic [7:0] subcommand_param;
    logic [27:0] max_lba;
    logic [27:0] nv_lba;
    logic nv_set_seen;
    logic nv_write;
    logic [7:0] block_count;
    logic multi_en;
    logic err;
    logic abrt;
    logic range_err;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
  } regs_type;

  regs_type s;
  regs_type n;

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    case (b)
      ata_cmd_pkg::OFF_COMMAND: reg_index = ata_cmd_pkg::IDX_COMMAND;
      ata_cmd_pkg::OFF_DRIVE_HEAD: reg_index = ata_cmd_pkg::IDX_DRIVE_HEAD;
      ata_cmd_pkg::OFF_LBA_HIGH: reg_index = ata_cmd_pkg::IDX_LBA_HIGH;
      ata_cmd_pkg::OFF_LBA_MID: reg_index = ata_cmd_pkg::IDX_LBA_MID;
      ata_cmd_pkg::OFF_LBA_LOW: reg_index = ata_cmd_pkg::IDX_LBA_LOW;
      ata_cmd_pkg::OFF_COUNT: reg_index = ata_cmd_pkg::IDX_COUNT;
      ata_cmd_pkg::OFF_SUBCMD: reg_index = ata_cmd_pkg::IDX_SUBCMD;
      ata_cmd_pkg::OFF_STATUS: reg_index = ata_cmd_pkg::IDX_STATUS;
      ata_cmd_pkg::OFF_MAX_LBA: reg_index = ata_cmd_pkg::IDX_MAX_LBA;
      ata_cmd_pkg::OFF_NV_LBA: reg_index = ata_cmd_pkg::IDX_NV_LBA;
      ata_cmd_pkg::OFF_BLOCK: reg_index = ata_cmd_pkg::IDX_BLOCK;
      ata_cmd_pkg::OFF_IRQ_STAT: reg_index = ata_cmd_pkg::IDX_IRQ_STAT;
      ata_cmd_pkg::OFF_IRQ_MASK: reg_index = ata_cmd_pkg::IDX_IRQ_MASK;
      default: reg_index = ata_cmd_pkg::IDX_NONE;
    endcase
  endfunction : reg_index

  // Supported block counts: powers of two up to MAX_BLOCK
  function automatic logic count_ok(input logic [7:0] c);
    count_ok = (c != 8'h00) && ((c & (c - 8'h01)) == 8'h00) && (c <= MAX_BLOCK);
  endfunction : count_ok

  // Address formed from the task file
  function automatic logic [27:0] tf_lba(input regs_type r);
    tf_lba = {r.drive_head_select[3:0], r.lba_high_byte, r.lba_mid_byte, r.lba_low_byte};
  endfunction : tf_lba

  logic [27:0] cur_lba;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic do_write;
  logic [7:0] wbyte;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic persist;

  assign cur_lba = tf_lba(s);
  assign persist = s.transfer_count_param[ata_cmd_pkg::COUNT_PERSIST_BIT];
  assign wr_idx = reg_index(s.aw_addr);
  assign rd_idx = reg_index(s_axi_araddr);
  assign do_write = s.aw_held && s.w_held && !s.bvalid;
  assign wbyte = s.wdata[7:0];

  always_comb begin
    n = s;
    n.nv_write = 1'b0;
    irq_set = 2'h0;
    irq_clr = 2'h0;
    // Command execution uses the registered task file
    case (s.state)
      ata_cmd_pkg::ST_LOAD: begin
        n.max_lba = nv_limit_in;
        n.nv_lba = nv_limit_in;
        n.state = ata_cmd_pkg::ST_IDLE;
      end
      ata_cmd_pkg::ST_IDLE: begin
      end
      ata_cmd_pkg::ST_EXEC: begin
        n.state = ata_cmd_pkg::ST_IDLE;
        n.abrt = 1'b0;
        n.range_err = 1'b0;
        case (s.command_code)
          ata_cmd_pkg::CMD_SET_MAX: begin
            if (!s.drive_head_select[ata_cmd_pkg::DH_LBA_MODE_BIT]
                || cur_lba > NATIVE_MAX_LBA) begin
              n.abrt = 1'b1;
            end else if (persist && s.nv_set_seen) begin
              n.abrt = 1'b1;
            end else begin
              n.max_lba = cur_lba;
              if (persist) begin
                n.nv_lba = cur_lba;
                n.nv_set_seen = 1'b1;
                n.nv_write = 1'b1;
              end
            end
          end
          ata_cmd_pkg::CMD_READ_NATIVE: begin
            n.drive_head_select[3:0] = NATIVE_MAX_LBA[27:24];
            n.lba_high_byte = NATIVE_MAX_LBA[23:16];
            n.lba_mid_byte = NATIVE_MAX_LBA[15:8];
            n.lba_low_byte = NATIVE_MAX_LBA[7:0];
          end
          ata_cmd_pkg::CMD_SET_MULTI: begin
            if (s.transfer_count_param == 8'h00) begin
              n.multi_en = 1'b0;
            end else if (count_ok(s.transfer_count_param)) begin
              n.block_count = s.transfer_count_param;
              n.multi_en = 1'b1;
            end else begin
              n.abrt = 1'b1;
              n.multi_en = 1'b0;
            end
          end
          ata_cmd_pkg::CMD_READ_SECTORS, ata_cmd_pkg::CMD_WRITE_SECTORS,
          ata_cmd_pkg::CMD_READ_MULTI, ata_cmd_pkg::CMD_WRITE_MULTI: begin
            if (cur_lba > s.max_lba) begin
              n.abrt = 1'b1;
              n.range_err = 1'b1;
            end else if ((s.command_code == ata_cmd_pkg::CMD_READ_MULTI
                || s.command_code == ata_cmd_pkg::CMD_WRITE_MULTI) && !s.multi_en) begin
              n.abrt = 1'b1;
            end
          end
          default: n.abrt = 1'b1;
        endcase
        n.err = n.abrt;
        irq_set[ata_cmd_pkg::IRQ_DONE_BIT] = 1'b1;
        irq_set[ata_cmd_pkg::IRQ_ABORT_BIT] = n.abrt;
      end
      default: n.state = ata_cmd_pkg::ST_IDLE;
    endcase

    // Write channel: address and data taken in either order
    if (!s.aw_held && s_axi_awvalid) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (!s.w_held && s_axi_wvalid) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (do_write) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wr_idx == ata_cmd_pkg::IDX_NONE) ? ata_cmd_pkg::RESP_SLVERR
                                                  : ata_cmd_pkg::RESP_OKAY;
      // Task file is frozen while busy, as a drive ignores writes then
      if (s.wstrb[0] && s.state == ata_cmd_pkg::ST_IDLE) begin
        case (wr_idx)
          ata_cmd_pkg::IDX_COMMAND: begin
            n.command_code = wbyte;
            if (s.drive_head_select[ata_cmd_pkg::DH_SELECT_BIT] == device_position) begin
              n.state = ata_cmd_pkg::ST_EXEC;
            end
          end
          ata_cmd_pkg::IDX_DRIVE_HEAD: n.drive_head_select = wbyte;
          ata_cmd_pkg::IDX_LBA_HIGH: n.lba_high_byte = wbyte;
          ata_cmd_pkg::IDX_LBA_MID: n.lba_mid_byte = wbyte;
          ata_cmd_pkg::IDX_LBA_LOW: n.lba_low_byte = wbyte;
          ata_cmd_pkg::IDX_COUNT: n.transfer_count_param = wbyte;
          ata_cmd_pkg::IDX_SUBCMD: n.subcommand_param = wbyte;
          default: begin
          end
        endcase
      end
      if (s.wstrb[0] && wr_idx == ata_cmd_pkg::IDX_IRQ_MASK) begin
        n.irq_mask = wbyte[1:0];
      end
    end

    // Read channel; the interrupt status clears on read
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (!s.rvalid && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = ata_cmd_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      case (rd_idx)
        ata_cmd_pkg::IDX_DRIVE_HEAD: n.rdata[7:0] = s.drive_head_select;
        ata_cmd_pkg::IDX_LBA_HIGH: n.rdata[7:0] = s.lba_high_byte;
        ata_cmd_pkg::IDX_LBA_MID: n.rdata[7:0] = s.lba_mid_byte;
        ata_cmd_pkg::IDX_LBA_LOW: n.rdata[7:0] = s.lba_low_byte;
        ata_cmd_pkg::IDX_COUNT: n.rdata[7:0] = s.transfer_count_param;
        ata_cmd_pkg::IDX_STATUS: begin
          n.rdata[ata_cmd_pkg::ST_BUSY_BIT] = (s.state != ata_cmd_pkg::ST_IDLE);
          n.rdata[ata_cmd_pkg::ST_ERROR_BIT] = s.err;
          n.rdata[ata_cmd_pkg::ST_ABORT_BIT] = s.abrt;
          n.rdata[ata_cmd_pkg::ST_MULTI_BIT] = s.multi_en;
          n.rdata[ata_cmd_pkg::ST_RANGE_BIT] = s.range_err;
        end
        ata_cmd_pkg::IDX_MAX_LBA: n.rdata[27:0] = s.max_lba;
        ata_cmd_pkg::IDX_NV_LBA: n.rdata[27:0] = s.nv_lba;
        ata_cmd_pkg::IDX_BLOCK: n.rdata[7:0] = s.block_count;
        ata_cmd_pkg::IDX_IRQ_STAT: begin
          n.rdata[1:0] = s.irq_stat;
          irq_clr = s.irq_stat;
        end
        ata_cmd_pkg::IDX_IRQ_MASK: n.rdata[1:0] = s.irq_mask;
        ata_cmd_pkg::IDX_COMMAND, ata_cmd_pkg::IDX_SUBCMD: begin
        end
        default: n.rresp = ata_cmd_pkg::RESP_SLVERR;
      endcase
    end
    // A new event outlasts a read that clears in the same cycle
    n.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.state <= ata_cmd_pkg::ST_LOAD;
      s.max_lba <= ata_cmd_pkg::LBA_RESET;
      s.nv_lba <= ata_cmd_pkg::LBA_RESET;
      s.multi_en <= 1'b0;
      s.nv_set_seen <= 1'b0;
      s.irq_mask <= ata_cmd_pkg::IRQ_MASK_RESET;
      s.drive_head_select <= ata_cmd_pkg::TF_RESET;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = !s.aw_held;
  assign s_axi_wready = !s.w_held;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign nv_limit_out = s.nv_lba;
  assign nv_limit_write = s.nv_write;
  assign max_lba = s.max_lba;
  assign block_count = s.block_count;
  assign multi_enable = s.multi_en;
  assign device_busy_flag = (s.state != ata_cmd_pkg::ST_IDLE);
  assign irq = |(s.irq_stat & s.irq_mask);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  logic exec;
  assign exec = (s.state == ata_cmd_pkg::ST_EXEC);

  property p_busy_single;
    exec |=> !device_busy_flag;
  endproperty
  a_busy_single: assert property (p_busy_single) else $error("busy longer than one cycle");

  property p_zero_count;
    exec && s.command_code == ata_cmd_pkg::CMD_SET_MULTI && s.transfer_count_param == 8'h00
      |=> !multi_enable && !s.abrt;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count misbehaved");

  property p_bad_count;
    exec && s.command_code == ata_cmd_pkg::CMD_SET_MULTI && s.transfer_count_param != 8'h00
      && !count_ok(s.transfer_count_param) |=> s.abrt && !multi_enable;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad count not aborted");

  property p_good_count;
    exec && s.command_code == ata_cmd_pkg::CMD_SET_MULTI && count_ok(s.transfer_count_param)
      |=> multi_enable && block_count == $past(s.transfer_count_param) && !s.abrt;
  endproperty
  a_good_count: assert property (p_good_count) else $error("good count not loaded");

  property p_second_nv;
    exec && s.command_code == ata_cmd_pkg::CMD_SET_MAX && persist && s.nv_set_seen
      |=> s.abrt && $stable(nv_limit_out) && !nv_limit_write;
  endproperty
  a_second_nv: assert property (p_second_nv) else $error("second persistent change taken");

  property p_set_max;
    exec && s.command_code == ata_cmd_pkg::CMD_SET_MAX && !(persist && s.nv_set_seen)
      && s.drive_head_select[ata_cmd_pkg::DH_LBA_MODE_BIT] && cur_lba <= NATIVE_MAX_LBA
      |=> max_lba == $past(cur_lba) && nv_limit_write == $past(persist);
  endproperty
  a_set_max: assert property (p_set_max) else $error("limit not replaced");

  property p_range;
    exec && s.command_code == ata_cmd_pkg::CMD_READ_SECTORS && cur_lba > s.max_lba
      |=> s.abrt && s.range_err ##1 !device_busy_flag;
  endproperty
  a_range: assert property (p_range) else $error("access above limit accepted");

  property p_load;
    s.state == ata_cmd_pkg::ST_LOAD |-> !multi_enable ##1 max_lba == $past(nv_limit_in);
  endproperty
  a_load: assert property (p_load) else $error("reset load wrong");

  property p_unselected;
    do_write && wr_idx == ata_cmd_pkg::IDX_COMMAND
      && s.drive_head_select[ata_cmd_pkg::DH_SELECT_BIT] != device_position |=> !exec;
  endproperty
  a_unselected: assert property (p_unselected) else $error("unselected device acted");

  c_nv_set: cover property (exec && s.command_code == ata_cmd_pkg::CMD_SET_MAX && persist);
  c_multi_on: cover property (exec && s.command_code == ata_cmd_pkg::CMD_SET_MULTI ##1 multi_enable);
  c_range: cover property (s.range_err && irq);
endmodule : capacity_limit_and_block_count_cmds

`default_nettype wire

//--- tb/nv_limit_store.sv
// Non-volatile limit store model at the far side of the command block
`timescale 1ns/1ps
`default_nettype none
module nv_limit_store #(
  parameter logic [27:0] INIT = 28'h0000000
) (
  input wire logic sys_clk,
  input wire logic nv_limit_write,
  input wire logic [27:0] nv_limit_out,
  output logic [27:0] nv_limit_in
);
  // No reset here: the stored limit has to outlive the device's reset
  initial begin
    nv_limit_in = INIT;
  end
  always @(posedge sys_clk) begin
    if (nv_limit_write === 1'b1) begin
      nv_limit_in <= nv_limit_out;
    end
  end
endmodule : nv_limit_store
`default_nettype wire

//--- tb/capacity_limit_and_block_count_cmds_tb.sv
// Self-checking bench for the capacity-limit and block-count command block
`timescale 1ns/1ps
`default_nettype none
module capacity_limit_and_block_count_cmds_tb;
  localparam logic [27:0] NATIVE = 28'h00FFFFF;
  localparam logic [27:0] NV_INIT = 28'h0001234;
  localparam logic [7:0] MAXB = 8'h10;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic dev_pos = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, mx;
  logic [31:0] s_axi_rdata, rd;
  logic [27:0] nv_limit_in, nv_limit_out, max_lba, lba, keep;
  logic nv_limit_write, multi_enable, device_busy_flag, irq;
  logic [7:0] block_count;
  logic [7:0] counts [6] = '{8'h10, 8'h03, 8'h08, 8'h00, 8'h20, 8'h01};
  int n_mismatch = 0;
  int n_compared = 0;
  int busy_cnt = 0;
  int cycles = 0;
  int b0;

  capacity_limit_and_block_count_cmds #(
    .NATIVE_MAX_LBA(NATIVE), .MAX_BLOCK(MAXB), .ADDR_W(8)
  ) capacity_limit_and_block_count_cmds_inst (
    .sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .device_position(dev_pos), .nv_limit_in,
    .nv_limit_out, .nv_limit_write, .max_lba, .block_count, .multi_enable,
    .device_busy_flag, .irq
  );
  nv_limit_store #(.INIT(NV_INIT)) nv_limit_store_inst (
    .sys_clk, .nv_limit_write, .nv_limit_out, .nv_limit_in
  );

  always #2 sys_clk = ~sys_clk;

  // Busy cycles counted so a command's busy window can be measured
  always @(posedge sys_clk) begin
    busy_cnt <= busy_cnt + ((device_busy_flag === 1'b1) ? 1 : 0);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_resp

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ta, tw, bd;
    int n;
    bd = 0;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd && n < 100) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready === 1'b1;
      tw = s_axi_wvalid && s_axi_wready === 1'b1;
      bd = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    check("write answered", 32'h1, {31'h0, bd});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ta, rdn;
    int n;
    rdn = 0;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rdn && n < 100) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready === 1'b1;
      rdn = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    check("read answered", 32'h1, {31'h0, rdn});
  endtask : axi_read

  // Loads the task file, writes the command last, then lets it finish
  task automatic run_cmd(input logic [7:0] c, input logic [27:0] a, input logic md,
                         input logic sel, input logic [7:0] cnt);
    axi_write(ata_cmd_pkg::OFF_DRIVE_HEAD, {24'h0, 1'b0, md, 1'b0, sel, a[27:24]}, rsp);
    axi_write(ata_cmd_pkg::OFF_LBA_HIGH, {24'h0, a[23:16]}, rsp);
    axi_write(ata_cmd_pkg::OFF_LBA_MID, {24'h0, a[15:8]}, rsp);
    axi_write(ata_cmd_pkg::OFF_LBA_LOW, {24'h0, a[7:0]}, rsp);
    axi_write(ata_cmd_pkg::OFF_COUNT, {24'h0, cnt}, rsp);
    b0 = busy_cnt;
    axi_write(ata_cmd_pkg::OFF_COMMAND, {24'h0, c}, rsp);
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : run_cmd

  task automatic status_is(input logic ab, input logic rg);
    axi_read(ata_cmd_pkg::OFF_STATUS, rd, rsp);
    check("abort flag", {31'h0, ab}, {31'h0, rd[ata_cmd_pkg::ST_ABORT_BIT]});
    check("error flag", {31'h0, ab}, {31'h0, rd[ata_cmd_pkg::ST_ERROR_BIT]});
    check("range flag", {31'h0, rg}, {31'h0, rd[ata_cmd_pkg::ST_RANGE_BIT]});
  endtask : status_is

  task automatic do_reset;
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : do_reset

  function automatic logic [1:0] multi_exp(input logic [7:0] c);
    if (c == 8'h00) return 2'b00;
    if ((c & (c - 8'h01)) == 8'h00 && c <= MAXB) return 2'b01;
    return 2'b10;
  endfunction : multi_exp

  initial begin
    void'($urandom(38));
    dev_pos <= 1'($urandom);
    do_reset();
    check("limit after reset", {4'h0, NV_INIT}, {4'h0, max_lba});
    check("multi after reset", 32'h0, {31'h0, multi_enable});
    run_cmd(ata_cmd_pkg::CMD_READ_MULTI, 28'h0, 1'b1, dev_pos, 8'h01);
    status_is(1'b1, 1'b0);
    $display("test reset defaults done");
    // Boot flow: learn native size, open it up
    run_cmd(ata_cmd_pkg::CMD_READ_NATIVE, 28'h0, 1'b1, dev_pos, 8'h00);
    axi_read(ata_cmd_pkg::OFF_LBA_LOW, rd, rsp);
    check("native low", {24'h0, NATIVE[7:0]}, rd);
    axi_read(ata_cmd_pkg::OFF_LBA_MID, rd, rsp);
    check("native mid", {24'h0, NATIVE[15:8]}, rd);
    axi_read(ata_cmd_pkg::OFF_LBA_HIGH, rd, rsp);
    check("native high", {24'h0, NATIVE[23:16]}, rd);
    axi_read(ata_cmd_pkg::OFF_DRIVE_HEAD, rd, rsp);
    check("native top", {28'h0, NATIVE[27:24]}, {28'h0, rd[3:0]});
    for (int i = 0; i < 5; i++) begin
      lba = (i == 0) ? NATIVE : 28'($urandom_range(32'(NATIVE), 0));
      run_cmd(ata_cmd_pkg::CMD_SET_MAX, lba, 1'b1, dev_pos, 8'h00);
      check("limit set", {4'h0, lba}, {4'h0, max_lba});
      check("busy cycles", 32'd1, 32'(busy_cnt - b0));
      check("nv untouched", {4'h0, NV_INIT}, {4'h0, nv_limit_in});
    end
    keep = lba;
    run_cmd(ata_cmd_pkg::CMD_SET_MAX, 28'h0000010, 1'b0, dev_pos, 8'h00);
    status_is(1'b1, 1'b0);
    run_cmd(ata_cmd_pkg::CMD_SET_MAX, NATIVE + 28'h1, 1'b1, dev_pos, 8'h00);
    status_is(1'b1, 1'b0);
    run_cmd(ata_cmd_pkg::CMD_SET_MAX, 28'h0000010, 1'b1, ~dev_pos, 8'h00);
    check("other device busy", 32'd0, 32'(busy_cnt - b0));
    check("limit kept", {4'h0, keep}, {4'h0, max_lba});
    $display("test volatile limit done");
    // Above the limit ordinary accesses fail, at the limit they pass
    for (int i = 0; i < 2; i++) begin
      run_cmd(i ? ata_cmd_pkg::CMD_WRITE_SECTORS : ata_cmd_pkg::CMD_READ_SECTORS,
              keep + 28'h1, 1'b1, dev_pos, 8'h01);
      status_is(1'b1, 1'b1);
      run_cmd(i ? ata_cmd_pkg::CMD_WRITE_SECTORS : ata_cmd_pkg::CMD_READ_SECTORS,
              keep, 1'b1, dev_pos, 8'h01);
      status_is(1'b0, 1'b0);
    end
    $display("test range done");
    lba = 28'($urandom_range(32'(NATIVE), 0));
    run_cmd(ata_cmd_pkg::CMD_SET_MAX, lba, 1'b1, dev_pos, 8'h01);
    check("persistent store", {4'h0, lba}, {4'h0, nv_limit_in});
    check("nv limit out", {4'h0, lba}, {4'h0, nv_limit_out});
    status_is(1'b0, 1'b0);
    run_cmd(ata_cmd_pkg::CMD_SET_MAX, 28'h0000022, 1'b1, dev_pos, 8'h01);
    status_is(1'b1, 1'b0);
    check("second nv kept", {4'h0, lba}, {4'h0, max_lba});
    // Shutdown flow: volatile full size, then reset brings back the stored one
    run_cmd(ata_cmd_pkg::CMD_SET_MAX, NATIVE, 1'b1, dev_pos, 8'h00);
    check("volatile full", {4'h0, NATIVE}, {4'h0, max_lba});
    do_reset();
    check("revert on reset", {4'h0, lba}, {4'h0, max_lba});
    run_cmd(ata_cmd_pkg::CMD_SET_MAX, 28'h0000033, 1'b1, dev_pos, 8'h01);
    status_is(1'b0, 1'b0);
    $display("test persistent limit done");
    for (int i = 0; i < 7; i++) begin
      keep[7:0] = (i == 6) ? 8'($urandom) : counts[i];
      run_cmd(ata_cmd_pkg::CMD_SET_MULTI, 28'h0, 1'b1, dev_pos, keep[7:0]);
      check("multi busy", 32'd1, 32'(busy_cnt - b0));
      mx = multi_exp(keep[7:0]);
      check("multi enable", {31'h0, mx[0]}, {31'h0, multi_enable});
      status_is(mx[1], 1'b0);
      if (mx == 2'b01) begin
        check("block count", {24'h0, keep[7:0]}, {24'h0, block_count});
      end
    end
    run_cmd(ata_cmd_pkg::CMD_SET_MULTI, 28'h0, 1'b1, dev_pos, 8'h02);
    run_cmd(ata_cmd_pkg::CMD_WRITE_MULTI, 28'h0, 1'b1, dev_pos, 8'h02);
    status_is(1'b0, 1'b0);
    axi_read(ata_cmd_pkg::OFF_BLOCK, rd, rsp);
    check("block reg", 32'h2, rd);
    $display("test block count done");
    // Only abort is unmasked, so a clean command must leave the line low
    axi_write(ata_cmd_pkg::OFF_IRQ_MASK, 32'h2, rsp);
    axi_read(ata_cmd_pkg::OFF_IRQ_STAT, rd, rsp);
    run_cmd(ata_cmd_pkg::CMD_READ_NATIVE, 28'h0, 1'b1, dev_pos, 8'h00);
    check("masked done", 32'h0, {31'h0, irq});
    run_cmd(8'hE5, 28'h0, 1'b1, dev_pos, 8'h00);
    check("abort irq", 32'h1, {31'h0, irq});
    axi_read(ata_cmd_pkg::OFF_IRQ_STAT, rd, rsp);
    check("irq status", 32'h3, rd);
    #1;
    check("irq cleared", 32'h0, {31'h0, irq});
    axi_write(ata_cmd_pkg::OFF_MAX_LBA, 32'h5, rsp);
    check("read-only limit", 32'h33, {4'h0, max_lba});
    axi_read(ata_cmd_pkg::OFF_MAX_LBA, rd, rsp);
    check("limit reg", 32'h33, rd);
    axi_write(8'h40, 32'h1, rsp);
    check_resp("unmapped write", ata_cmd_pkg::RESP_SLVERR, rsp);
    axi_read(8'h40, rd, rsp);
    check_resp("unmapped read", ata_cmd_pkg::RESP_SLVERR, rsp);
    $display("test interrupt and map done");
    print_verdict();
  end
endmodule : capacity_limit_and_block_count_cmds_tb
`default_nettype wire
